// file: src/mctp_pkg.sv
// Package: register map, time units, channels and state of the timing bank
package mctp_pkg;

  // ************************************************************
  // Register slots, word indices and reset values
  // ************************************************************
  localparam int MCTP_NREG = 32;
  localparam int MCTP_NCH  = 21;

  typedef enum logic [4:0] {
    MCTP_S_BUSY_ON, MCTP_S_BUSY_OFF, MCTP_S_BUSY_TOL, MCTP_S_RB_ON,
    MCTP_S_RB_OFF, MCTP_S_RB_TOL, MCTP_S_DIAL_QUAL, MCTP_S_ANS_SEC,
    MCTP_S_ANS_DATA, MCTP_S_UNSCR_MIN, MCTP_S_SCR_DLY, MCTP_S_SCR_LEN,
    MCTP_S_HS_LO, MCTP_S_HS_HI, MCTP_S_S1_LEN, MCTP_S_ONES1200,
    MCTP_S_HISPD_LO, MCTP_S_HISPD_HI, MCTP_S_INTR_SUSP, MCTP_S_ANS_ONES,
    MCTP_S_DT_CARR, MCTP_S_DT_TMO, MCTP_S_SLV_LOSS, MCTP_S_RT_TMO,
    MCTP_S_FSK_LO, MCTP_S_FSK_HI, MCTP_S_ANS_DET, MCTP_S_OVC_DLY,
    MCTP_S_ANS_FINE, MCTP_S_CALL_ONES, MCTP_S_KISS_MIN, MCTP_S_INTR_CTL
  } mctp_slot_t;

  // Byte address is four times the index
  localparam logic [7:0] MCTP_IDX [MCTP_NREG] = '{
    8'h16, 8'h17, 8'h18, 8'h19, 8'h1A, 8'h1B, 8'h1C, 8'h1E,
    8'h1F, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26,
    8'h27, 8'h28, 8'h29, 8'h2A, 8'h2B, 8'h2C, 8'h2D, 8'h2E,
    8'h2F, 8'h30, 8'h31, 8'h32, 8'h34, 8'h35, 8'h36, 8'h82};

  localparam logic [7:0] MCTP_RST [MCTP_NREG] = '{
    8'h32, 8'h32, 8'h0F, 8'h26, 8'h4B, 8'h07, 8'h0A, 8'h03,
    8'h2D, 8'h00, 8'h00, 8'hA2, 8'hCB, 8'h08, 8'h3C, 8'h0C,
    8'h78, 8'h08, 8'h00, 8'hD2, 8'h18, 8'h08, 8'h0C, 8'hF0,
    8'h3C, 8'h00, 8'h3C, 8'h0C, 8'h5A, 8'h00, 8'h30, 8'h08};

  // Read-only status words, four in a row
  localparam logic [7:0] MCTP_IDX_STAT   = 8'h70;
  localparam int         MCTP_INTR_LSB   = 1;
  localparam logic [1:0] MCTP_INTR_SUSP  = 2'h2;

  // ************************************************************
  // Time units and cycle counts at 100 MHz
  // ************************************************************
  localparam int  MCTP_CLK_MHZ    = 100;
  localparam real MCTP_U10_MS     = 10.0;
  localparam real MCTP_U5_3_MS    = 5.0 / 3.0;
  localparam real MCTP_U53_MS     = 53.333;
  localparam real MCTP_U500_MS    = 500.0;
  localparam real MCTP_U1S_MS     = 1000.0;
  localparam real MCTP_DT_BASE_MS = 426.66;
  localparam int  MCTP_CYC_10MS   = int'(MCTP_U10_MS * 1000.0 * MCTP_CLK_MHZ);
  localparam int  MCTP_CYC_5_3MS  = int'(MCTP_U5_3_MS * 1000.0 * MCTP_CLK_MHZ);
  localparam int  MCTP_CYC_53MS   = int'(MCTP_U53_MS * 1000.0 * MCTP_CLK_MHZ);
  localparam int  MCTP_CYC_500MS  = int'(MCTP_U500_MS * 1000.0 * MCTP_CLK_MHZ);
  localparam int  MCTP_CYC_1S     = int'(MCTP_U1S_MS * 1000.0 * MCTP_CLK_MHZ);
  localparam logic [16:0] MCTP_DT_BASE =
    17'(int'(MCTP_DT_BASE_MS / MCTP_U5_3_MS));

  typedef enum logic [2:0] {
    MCTP_U_10MS  = 3'b000,
    MCTP_U_5_3MS = 3'b001,
    MCTP_U_53MS  = 3'b010,
    MCTP_U_500MS = 3'b011,
    MCTP_U_1S    = 3'b100
  } mctp_unit_t;

  // ************************************************************
  // Timed channels and module state
  // ************************************************************
  typedef enum logic [4:0] {
    MCTP_C_DIAL, MCTP_C_ANS_TONE, MCTP_C_ANS_DATA, MCTP_C_UNSCR,
    MCTP_C_SCR_DLY, MCTP_C_SCR_SEND, MCTP_C_HS_DLY, MCTP_C_S1,
    MCTP_C_ONES1200, MCTP_C_HISPD, MCTP_C_INTR, MCTP_C_ANS_ONES,
    MCTP_C_DT_CARR, MCTP_C_DT_TMO, MCTP_C_SLV_LOSS, MCTP_C_RT_TMO,
    MCTP_C_FSK, MCTP_C_ANS_DET, MCTP_C_OVC, MCTP_C_KISS, MCTP_C_CALL_ONES
  } mctp_chan_t;

  typedef struct packed {
    logic [MCTP_NREG-1:0][7:0]  regs;
    logic [4:0][31:0]           div;
    logic [4:0]                 tick;
    logic [MCTP_NCH-1:0]        run;
    logic [MCTP_NCH-1:0]        lim;
    logic [MCTP_NCH-1:0]        busy;
    logic [MCTP_NCH-1:0]        done;
    logic [MCTP_NCH-1:0][16:0]  cnt;
    logic [MCTP_NCH-1:0][16:0]  len;
    logic [MCTP_NCH-1:0][2:0]   unit;
    logic [1:0]                 tlvl;
    logic [1:0]                 ton_ok;
    logic [1:0]                 tvalid;
    logic [1:0][8:0]            ton;
    logic [1:0][8:0]            toff;
    logic [31:0]                prdata;
    logic                       pready;
    logic                       pslverr;
  } mctp_state_t;

endpackage : mctp_pkg

// file: src/mctp_timing_bank.sv
// Call timing parameter bank with its timers and cadence checkers
//
// Chosen here: the APB register port.
`timescale 1ns/1ps

// Operation
// - Busy cadence valid strictly inside on/off tolerance
// - Ringback on/off nominals, 53.333 ms units
// - Ringback valid strictly inside tolerance window
// - Dial tone needs continuous qualify time
// - Answer tone seconds, else fine length
// - Delay from answer tone to data
// - Unscrambled ones must persist minimum time
// - Delay before sending scrambled ones
// - Scrambled ones sent for set length
// - Handshake-to-data delay from two bytes
// - S1 pattern sent for set duration
// - 1200 bps ones after S1 end
// - 2400 bps ones length from two bytes
// - Intrusion suspended only in mode 10
// - Answer side scrambled ones minimum
// - Direct turnaround carrier minimum and timeout
// - Slave carrier loss before reverse search
// - Reverse turnaround search time limit
// - FSK connection delay from two bytes
// - Answer tone detected after minimum time
// - Overcurrent checked after off-hook delay
// - Kissoff longer than minimum echoes k
module mctp_timing_bank #(
  parameter int P_CYC_10MS  = mctp_pkg::MCTP_CYC_10MS,
  parameter int P_CYC_5_3MS = mctp_pkg::MCTP_CYC_5_3MS,
  parameter int P_CYC_53MS  = mctp_pkg::MCTP_CYC_53MS,
  parameter int P_CYC_500MS = mctp_pkg::MCTP_CYC_500MS,
  parameter int P_CYC_1S    = mctp_pkg::MCTP_CYC_1S
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [20:0] chan_req,
  input  wire logic        busy_tone_in,
  input  wire logic        ringback_tone_in,
  input  wire logic        alarm_security_mode,
  output logic      [20:0] chan_busy,
  output logic      [20:0] chan_done,
  output logic             busy_tone_valid,
  output logic             ringback_valid
);

  localparam int NREG = mctp_pkg::MCTP_NREG;
  localparam int NCH  = mctp_pkg::MCTP_NCH;
  localparam int CYC [5] = '{P_CYC_10MS, P_CYC_5_3MS, P_CYC_53MS,
                             P_CYC_500MS, P_CYC_1S};

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic mctp_pkg::mctp_state_t rst_state();
    mctp_pkg::mctp_state_t s;
    s = '0;
    for (int k = 0; k < NREG; k++) begin
      s.regs[k] = mctp_pkg::MCTP_RST[k];
    end
    return s;
  endfunction : rst_state

  localparam mctp_pkg::mctp_state_t RST_STATE = rst_state();

  // Strict window: nom - tol < x < nom + tol
  function automatic logic in_window(
    input logic [8:0] x,
    input logic [7:0] nom,
    input logic [7:0] tol
  );
    logic [9:0] xw;
    logic [9:0] nw;
    logic [9:0] tw;
    xw = {1'b0, x};
    nw = {2'b00, nom};
    tw = {2'b00, tol};
    return (xw + tw > nw) && (xw < nw + tw);
  endfunction : in_window

  // Timeouts stop at len; minimums must pass len
  function automatic logic reached(
    input logic [16:0] cnt,
    input logic [16:0] len,
    input logic        lim
  );
    return lim ? (cnt >= len) : (cnt > len);
  endfunction : reached

  function automatic logic [16:0] byte_len(input logic [7:0] v);
    return {9'h000, v};
  endfunction : byte_len

  // Returns {limit, unit, length}
  function automatic logic [20:0] chan_cfg(
    input logic [4:0]                 ch,
    input logic [NREG-1:0][7:0]       r
  );
    logic [2:0]  u;
    logic [16:0] l;
    logic        lim;
    u   = mctp_pkg::MCTP_U_5_3MS;
    l   = '0;
    lim = 1'b0;
    case (ch)
      mctp_pkg::MCTP_C_DIAL: begin
        u = mctp_pkg::MCTP_U_10MS;
        l = byte_len(r[mctp_pkg::MCTP_S_DIAL_QUAL]);
      end
      mctp_pkg::MCTP_C_ANS_TONE: begin
        if (r[mctp_pkg::MCTP_S_ANS_SEC] != 8'h00) begin
          u = mctp_pkg::MCTP_U_1S;
          l = byte_len(r[mctp_pkg::MCTP_S_ANS_SEC]);
        end else begin
          l = byte_len(r[mctp_pkg::MCTP_S_ANS_FINE]);
        end
      end
      mctp_pkg::MCTP_C_ANS_DATA:
        l = byte_len(r[mctp_pkg::MCTP_S_ANS_DATA]);
      mctp_pkg::MCTP_C_UNSCR:
        l = byte_len(r[mctp_pkg::MCTP_S_UNSCR_MIN]);
      mctp_pkg::MCTP_C_SCR_DLY: begin
        u = mctp_pkg::MCTP_U_53MS;
        l = byte_len(r[mctp_pkg::MCTP_S_SCR_DLY]);
      end
      mctp_pkg::MCTP_C_SCR_SEND:
        l = byte_len(r[mctp_pkg::MCTP_S_SCR_LEN]);
      mctp_pkg::MCTP_C_HS_DLY:
        l = {1'b0, r[mctp_pkg::MCTP_S_HS_HI],
             r[mctp_pkg::MCTP_S_HS_LO]};
      mctp_pkg::MCTP_C_S1:
        l = byte_len(r[mctp_pkg::MCTP_S_S1_LEN]);
      mctp_pkg::MCTP_C_ONES1200: begin
        u = mctp_pkg::MCTP_U_53MS;
        l = byte_len(r[mctp_pkg::MCTP_S_ONES1200]);
      end
      mctp_pkg::MCTP_C_HISPD:
        l = {1'b0, r[mctp_pkg::MCTP_S_HISPD_HI],
             r[mctp_pkg::MCTP_S_HISPD_LO]};
      mctp_pkg::MCTP_C_INTR: begin
        u = mctp_pkg::MCTP_U_500MS;
        // Other modes: no suspension window at all
        if (r[mctp_pkg::MCTP_S_INTR_CTL][mctp_pkg::MCTP_INTR_LSB +: 2]
            == mctp_pkg::MCTP_INTR_SUSP) begin
          l = byte_len(r[mctp_pkg::MCTP_S_INTR_SUSP]);
        end
        lim = 1'b1;
      end
      mctp_pkg::MCTP_C_ANS_ONES:
        l = byte_len(r[mctp_pkg::MCTP_S_ANS_ONES]);
      mctp_pkg::MCTP_C_DT_CARR:
        l = byte_len(r[mctp_pkg::MCTP_S_DT_CARR]);
      mctp_pkg::MCTP_C_DT_TMO: begin
        l = mctp_pkg::MCTP_DT_BASE
            + byte_len(r[mctp_pkg::MCTP_S_DT_TMO]);
        lim = 1'b1;
      end
      mctp_pkg::MCTP_C_SLV_LOSS:
        l = byte_len(r[mctp_pkg::MCTP_S_SLV_LOSS]);
      mctp_pkg::MCTP_C_RT_TMO: begin
        l = byte_len(r[mctp_pkg::MCTP_S_RT_TMO]);
        lim = 1'b1;
      end
      mctp_pkg::MCTP_C_FSK:
        l = {1'b0, r[mctp_pkg::MCTP_S_FSK_HI],
             r[mctp_pkg::MCTP_S_FSK_LO]};
      mctp_pkg::MCTP_C_ANS_DET:
        l = byte_len(r[mctp_pkg::MCTP_S_ANS_DET]);
      mctp_pkg::MCTP_C_OVC:
        l = byte_len(r[mctp_pkg::MCTP_S_OVC_DLY]);
      mctp_pkg::MCTP_C_KISS: begin
        u = mctp_pkg::MCTP_U_10MS;
        l = byte_len(r[mctp_pkg::MCTP_S_KISS_MIN]);
      end
      mctp_pkg::MCTP_C_CALL_ONES:
        l = byte_len(r[mctp_pkg::MCTP_S_CALL_ONES]);
      default: begin
        l = '0;
      end
    endcase
    return {lim, u, l};
  endfunction : chan_cfg

  // ************************************************************
  // State
  // ************************************************************
  mctp_pkg::mctp_state_t s_q;
  mctp_pkg::mctp_state_t s_d;

  always_comb begin : next_p
    logic [20:0] cfg;
    logic [7:0]  idx;
    logic        acc;
    logic        req;
    logic [31:0] stat;
    logic        tin;
    logic        tk;
    logic [7:0]  non;
    logic [7:0]  noff;
    logic [7:0]  tol;
    cfg  = '0;
    idx  = paddr[9:2];
    acc  = psel && penable && s_q.pready;
    req  = 1'b0;
    stat = {6'h00, s_q.tvalid, 3'h0, s_q.done};
    tin  = 1'b0;
    tk   = 1'b0;
    non  = '0;
    noff = '0;
    tol  = '0;
    s_d  = s_q;

    // Unit dividers; one-cycle enables shared by all timers
    for (int u = 0; u < 5; u++) begin
      if (s_q.div[u] >= 32'(CYC[u] - 1)) begin
        s_d.div[u]  = '0;
        s_d.tick[u] = 1'b1;
      end else begin
        s_d.div[u]  = s_q.div[u] + 32'h1;
        s_d.tick[u] = 1'b0;
      end
    end

    // APB: answer prepared in setup, zero wait states
    s_d.pready = 1'b0;
    if (psel && !penable) begin
      s_d.pready  = 1'b1;
      s_d.prdata  = '0;
      s_d.pslverr = 1'b1;
      if (paddr[11:10] == 2'b00 && paddr[1:0] == 2'b00) begin
        for (int k = 0; k < NREG; k++) begin
          if (idx == mctp_pkg::MCTP_IDX[k]) begin
            s_d.prdata  = {24'h000000, s_q.regs[k]};
            s_d.pslverr = 1'b0;
          end
        end
        if (idx[7:2] == mctp_pkg::MCTP_IDX_STAT[7:2] && !pwrite) begin
          s_d.prdata  = {24'h000000, stat[{idx[1:0], 3'b000} +: 8]};
          s_d.pslverr = 1'b0;
        end
      end
    end
    if (acc && pwrite && !s_q.pslverr && pstrb[0]) begin
      for (int k = 0; k < NREG; k++) begin
        if (idx == mctp_pkg::MCTP_IDX[k]) begin
          s_d.regs[k] = pwdata[7:0];
        end
      end
    end

    // Timed channels; length and unit latched at start
    for (int i = 0; i < NCH; i++) begin
      cfg = chan_cfg(5'(i), s_q.regs);
      req = chan_req[i];
      if (i == mctp_pkg::MCTP_C_KISS) begin
        req = req && alarm_security_mode;
      end
      if (!req) begin
        // Dropping the request ends any qualification at once
        s_d.run[i] = 1'b0;
        s_d.cnt[i] = '0;
      end else if (!s_q.run[i]) begin
        s_d.run[i]  = 1'b1;
        s_d.cnt[i]  = '0;
        s_d.len[i]  = cfg[16:0];
        s_d.unit[i] = cfg[19:17];
        s_d.lim[i]  = cfg[20];
      end else if (s_q.tick[s_q.unit[i]]
                   && !reached(s_q.cnt[i], s_q.len[i], s_q.lim[i])) begin
        s_d.cnt[i] = s_q.cnt[i] + 17'h00001;
      end
      s_d.done[i] = s_d.run[i]
                    && reached(s_d.cnt[i], s_d.len[i], s_d.lim[i]);
      s_d.busy[i] = s_d.run[i] && !s_d.done[i];
    end

    // Cadence checkers: 0 busy tone, 1 ringback
    for (int t = 0; t < 2; t++) begin
      if (t == 0) begin
        tin  = busy_tone_in;
        tk   = s_q.tick[mctp_pkg::MCTP_U_10MS];
        non  = s_q.regs[mctp_pkg::MCTP_S_BUSY_ON];
        noff = s_q.regs[mctp_pkg::MCTP_S_BUSY_OFF];
        tol  = s_q.regs[mctp_pkg::MCTP_S_BUSY_TOL];
      end else begin
        tin  = ringback_tone_in;
        tk   = s_q.tick[mctp_pkg::MCTP_U_53MS];
        non  = s_q.regs[mctp_pkg::MCTP_S_RB_ON];
        noff = s_q.regs[mctp_pkg::MCTP_S_RB_OFF];
        tol  = s_q.regs[mctp_pkg::MCTP_S_RB_TOL];
      end
      s_d.tlvl[t] = tin;
      if (tin && !s_q.tlvl[t]) begin
        // Off period ends: judge the whole on/off pair
        s_d.tvalid[t] = s_q.ton_ok[t]
                        && in_window(s_q.toff[t], noff, tol);
        s_d.ton[t] = '0;
      end else if (!tin && s_q.tlvl[t]) begin
        s_d.ton_ok[t] = in_window(s_q.ton[t], non, tol);
        if (!s_d.ton_ok[t]) begin
          s_d.tvalid[t] = 1'b0;
        end
        s_d.toff[t] = '0;
      end else if (tk) begin
        // Saturate so a stuck tone never wraps into the window
        if (tin && s_q.ton[t] != 9'h1FF) begin
          s_d.ton[t] = s_q.ton[t] + 9'h001;
        end else if (!tin && s_q.toff[t] != 9'h1FF) begin
          s_d.toff[t] = s_q.toff[t] + 9'h001;
        end
      end
    end
  end : next_p

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= RST_STATE;
    end else begin
      s_q <= s_d;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign prdata          = s_q.prdata;
  assign pready          = s_q.pready;
  assign pslverr         = s_q.pslverr;
  assign chan_busy       = s_q.busy;
  assign chan_done       = s_q.done;
  assign busy_tone_valid = s_q.tvalid[0];
  assign ringback_valid  = s_q.tvalid[1];

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_busy_on_rise:
  assert property ($rose(busy_tone_valid) |->
                   $past(busy_tone_in, 1) && !$past(busy_tone_in, 2)
                   && $past(s_q.ton_ok[0], 1))
    else $error("busy tone valid outside a good cadence");

  a_rb_pair_ok:
  assert property ($rose(ringback_valid) |->
                   $past(s_q.ton_ok[1], 1)
                   && in_window($past(s_q.toff[1], 1),
                                $past(s_q.regs[mctp_pkg::MCTP_S_RB_OFF], 1),
                                $past(s_q.regs[mctp_pkg::MCTP_S_RB_TOL], 1)))
    else $error("ringback accepted with off time out of window");

  a_dial_drop:
  assert property (!chan_req[mctp_pkg::MCTP_C_DIAL] |=>
                   !chan_done[mctp_pkg::MCTP_C_DIAL]
                   && !chan_busy[mctp_pkg::MCTP_C_DIAL])
    else $error("dial tone qualified without continuous request");

  a_ans_unit_sel:
  assert property (chan_req[mctp_pkg::MCTP_C_ANS_TONE]
                   && !s_q.run[mctp_pkg::MCTP_C_ANS_TONE] |=>
                   s_q.unit[mctp_pkg::MCTP_C_ANS_TONE] ==
                   ($past(s_q.regs[mctp_pkg::MCTP_S_ANS_SEC]) != 8'h00 ?
                    3'(mctp_pkg::MCTP_U_1S) : 3'(mctp_pkg::MCTP_U_5_3MS)))
    else $error("answer tone used the wrong time unit");

  a_hs_two_bytes:
  assert property (chan_req[mctp_pkg::MCTP_C_HS_DLY]
                   && !s_q.run[mctp_pkg::MCTP_C_HS_DLY] |=>
                   s_q.len[mctp_pkg::MCTP_C_HS_DLY] ==
                   {1'b0, $past(s_q.regs[mctp_pkg::MCTP_S_HS_HI]),
                    $past(s_q.regs[mctp_pkg::MCTP_S_HS_LO])})
    else $error("handshake delay length not hi:lo");

  a_intr_mode_off:
  assert property (chan_req[mctp_pkg::MCTP_C_INTR]
                   && !s_q.run[mctp_pkg::MCTP_C_INTR]
                   && s_q.regs[mctp_pkg::MCTP_S_INTR_CTL][2:1] != 2'h2 |=>
                   ##1 !chan_busy[mctp_pkg::MCTP_C_INTR])
    else $error("intrusion suspended outside mode 10");

  a_dt_tmo_len:
  assert property (chan_req[mctp_pkg::MCTP_C_DT_TMO]
                   && !s_q.run[mctp_pkg::MCTP_C_DT_TMO] |=>
                   s_q.len[mctp_pkg::MCTP_C_DT_TMO] == 17'h00100
                   + {9'h000, $past(s_q.regs[mctp_pkg::MCTP_S_DT_TMO])})
    else $error("direct turnaround timeout base wrong");

  a_kiss_gate:
  assert property (!alarm_security_mode |=>
                   !s_q.run[mctp_pkg::MCTP_C_KISS])
    else $error("kissoff timer ran outside alarm modes");

  a_reg_write:
  assert property (psel && penable && pready && pwrite && pstrb[0]
                   && paddr == 12'h070 |=>
                   s_q.regs[mctp_pkg::MCTP_S_DIAL_QUAL] ==
                   $past(pwdata[7:0]))
    else $error("register write not stored");

  a_done_latch:
  assert property ($rose(chan_done[mctp_pkg::MCTP_C_S1]) |->
                   $past(chan_req[mctp_pkg::MCTP_C_S1], 1)
                   && s_q.cnt[mctp_pkg::MCTP_C_S1]
                      > s_q.len[mctp_pkg::MCTP_C_S1])
    else $error("S1 time ended before its length");

endmodule : mctp_timing_bank

// file: verif/tb.sv
// Self-checking testbench for the call timing parameter bank
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
  n_fail++; $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end

module tb;
  // ************************************************************
  // Small unit periods keep every timed run short
  // ************************************************************
  localparam int U10  = 4;
  localparam int U5   = 5;
  localparam int U53  = 6;
  localparam int U500 = 7;
  localparam int U1S  = 8;

  // Single-byte minimum channels on 5/3 ms and their word indices
  localparam int         SCH [10] = '{2, 3, 5, 7, 11, 12, 14, 17, 18, 20};
  localparam logic [7:0] SIX [10] = '{8'h1F, 8'h20, 8'h22, 8'h25, 8'h2A,
                                      8'h2B, 8'h2D, 8'h31, 8'h32, 8'h35};

  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [20:0] chan_req;
  logic        busy_tone_in;
  logic        ringback_tone_in;
  logic        alarm_security_mode;
  logic [20:0] chan_busy;
  logic [20:0] chan_done;
  logic        busy_tone_valid;
  logic        ringback_valid;
  int          n_fail;
  int          samples_checked;
  int          cyc;

  mctp_timing_bank #(.P_CYC_10MS(U10), .P_CYC_5_3MS(U5),
    .P_CYC_53MS(U53), .P_CYC_500MS(U500), .P_CYC_1S(U1S)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chan_req(chan_req), .busy_tone_in(busy_tone_in),
    .ringback_tone_in(ringback_tone_in),
    .alarm_security_mode(alarm_security_mode), .chan_busy(chan_busy),
    .chan_done(chan_done), .busy_tone_valid(busy_tone_valid),
    .ringback_valid(ringback_valid));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Hang guard, well above the few thousand cycles the tests need
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      test_done;
    end
  end

  // ************************************************************
  // Access and timing tasks
  // ************************************************************
  task acc(input logic w, input logic [7:0] idx, input logic [7:0] d,
           input logic [31:0] exp_d, input logic exp_e);
    begin
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= {2'b00, idx, 2'b00};
      pwdata  <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      // Ends when pready is high; only the bench timeout ends it if pready never rises
      do begin
        @(posedge pclk);
      end while (pready !== 1'b1);
      `CHK(pslverr, exp_e)
      if (!w) `CHK(prdata, exp_d)
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask : acc

  // Done must come after more than lo and at most hi cycles
  task chan(input int ch, input int lo, input int hi);
    int n;
    logic b;
    begin
      chan_req[ch] <= 1'b1;
      n = 0;
      b = 1'bx;
      do begin
        @(posedge pclk);
        n++;
        // Busy one edge after start, unless the length is already met
        if (n == 2) b = chan_busy[ch];
      end while (chan_done[ch] !== 1'b1 && n < 3000);
      `CHK(n > lo && n <= hi, 1'b1)
      `CHK(b, lo > 0)
      `CHK(chan_busy[ch], 1'b0)
      chan_req[ch] <= 1'b0;
      repeat (3) @(posedge pclk);
      `CHK(chan_done[ch], 1'b0)
      `CHK(chan_busy[ch], 1'b0)
    end
  endtask : chan

  task tone(input logic rb, input logic v);
    if (rb) ringback_tone_in <= v;
    else busy_tone_in <= v;
  endtask : tone

  task cad(input logic rb, input int on_c, input int off_c, input logic e);
    begin
      tone(rb, 1'b1);
      repeat (on_c) @(posedge pclk);
      tone(rb, 1'b0);
      repeat (off_c) @(posedge pclk);
      tone(rb, 1'b1);
      repeat (3) @(posedge pclk);
      `CHK(rb ? ringback_valid : busy_tone_valid, e)
      tone(rb, 1'b0);
      repeat (5) @(posedge pclk);
    end
  endtask : cad

  task test_done;
    begin
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
    end
  endtask : test_done

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'hF;
    chan_req = '0;
    {busy_tone_in, ringback_tone_in, alarm_security_mode} = 3'b000;
    presetn = 1'b0;
    n_fail = 0;
    samples_checked = 0;
    cyc = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    acc(1'b0, 8'h19, 8'h00, 32'h26, 1'b0);
    acc(1'b0, 8'h1A, 8'h00, 32'h4B, 1'b0);
    acc(1'b0, 8'h1B, 8'h00, 32'h07, 1'b0);
    acc(1'b0, 8'h1C, 8'h00, 32'h0A, 1'b0);
    for (int i = 0; i < mctp_pkg::MCTP_NREG; i++)
      acc(1'b0, mctp_pkg::MCTP_IDX[i], 8'h00,
          {24'h0, mctp_pkg::MCTP_RST[i]}, 1'b0);
    for (int i = 0; i < mctp_pkg::MCTP_NREG; i++)
      acc(1'b1, mctp_pkg::MCTP_IDX[i], 8'hA5 ^ 8'(i), 32'h0, 1'b0);
    for (int i = 0; i < mctp_pkg::MCTP_NREG; i++)
      acc(1'b0, mctp_pkg::MCTP_IDX[i], 8'h00,
          {24'h0, 8'hA5 ^ 8'(i)}, 1'b0);
    acc(1'b0, 8'h1D, 8'h00, 32'h0, 1'b1);
    acc(1'b1, 8'h70, 8'hFF, 32'h0, 1'b1);
    $display("test registers done");
    // Edge cycles drop a tick, so lengths sit a tick clear of the bounds
    acc(1'b1, 8'h16, 8'h0A, 32'h0, 1'b0);
    acc(1'b1, 8'h17, 8'h0A, 32'h0, 1'b0);
    acc(1'b1, 8'h18, 8'h02, 32'h0, 1'b0);
    cad(1'b0, 10 * U10, 10 * U10, 1'b1);
    cad(1'b0, 13 * U10, 10 * U10, 1'b0);
    cad(1'b0, 11 * U10, 10 * U10, 1'b1);
    cad(1'b0, 10 * U10, 8 * U10, 1'b0);
    acc(1'b1, 8'h19, 8'h05, 32'h0, 1'b0);
    acc(1'b1, 8'h1A, 8'h05, 32'h0, 1'b0);
    acc(1'b1, 8'h1B, 8'h02, 32'h0, 1'b0);
    cad(1'b1, 5 * U53, 5 * U53, 1'b1);
    cad(1'b1, 8 * U53, 5 * U53, 1'b0);
    cad(1'b1, 5 * U53, 2 * U53, 1'b0);
    $display("test cadence done");
    acc(1'b1, 8'h1C, 8'h03, 32'h0, 1'b0);
    chan(0, 3 * U10, 4 * U10 + 3);
    acc(1'b1, 8'h1E, 8'h01, 32'h0, 1'b0);
    chan(1, U1S, 2 * U1S + 3);
    acc(1'b1, 8'h1E, 8'h00, 32'h0, 1'b0);
    acc(1'b1, 8'h34, 8'h06, 32'h0, 1'b0);
    chan(1, 6 * U5, 7 * U5 + 3);
    acc(1'b1, 8'h21, 8'h02, 32'h0, 1'b0);
    chan(4, 2 * U53, 3 * U53 + 3);
    acc(1'b1, 8'h24, 8'h01, 32'h0, 1'b0);
    acc(1'b1, 8'h23, 8'h02, 32'h0, 1'b0);
    chan(6, 258 * U5, 259 * U5 + 3);
    acc(1'b1, 8'h2C, 8'h01, 32'h0, 1'b0);
    chan(13, 256 * U5, 257 * U5 + 3);
    for (int i = 0; i < 10; i++) begin
      acc(1'b1, SIX[i], 8'h02, 32'h0, 1'b0);
      chan(SCH[i], 2 * U5, 3 * U5 + 3);
    end
    acc(1'b1, 8'h26, 8'h02, 32'h0, 1'b0);
    chan(8, 2 * U53, 3 * U53 + 3);
    acc(1'b1, 8'h28, 8'h01, 32'h0, 1'b0);
    acc(1'b1, 8'h27, 8'h01, 32'h0, 1'b0);
    chan(9, 257 * U5, 258 * U5 + 3);
    acc(1'b1, 8'h2E, 8'h02, 32'h0, 1'b0);
    chan(15, U5, 2 * U5 + 3);
    acc(1'b1, 8'h30, 8'h01, 32'h0, 1'b0);
    acc(1'b1, 8'h2F, 8'h03, 32'h0, 1'b0);
    chan(16, 259 * U5, 260 * U5 + 3);
    acc(1'b1, 8'h29, 8'h02, 32'h0, 1'b0);
    acc(1'b1, 8'h82, 8'h04, 32'h0, 1'b0);
    chan(10, U500, 2 * U500 + 3);
    acc(1'b1, 8'h82, 8'h08, 32'h0, 1'b0);
    chan(10, 0, U500 + 1);
    acc(1'b1, 8'h36, 8'h02, 32'h0, 1'b0);
    chan_req[19] <= 1'b1;
    repeat (6 * U10) @(posedge pclk);
    `CHK(chan_done[19], 1'b0)
    chan_req[19] <= 1'b0;
    alarm_security_mode <= 1'b1;
    repeat (2) @(posedge pclk);
    chan(19, 2 * U10, 3 * U10 + 3);
    $display("test channels done");
    test_done;
  end
endmodule : tb
